// ===== touch_sense_map.svh
/*
  Register offsets, writable masks, reset values, field positions and
  decode tables for the touch sensing configuration bank.
  Assumes it is included by bare name from the design files.
*/
`ifndef TOUCH_SENSE_MAP_SVH
`define TOUCH_SENSE_MAP_SVH

// Register offsets on the host access port.
`define TS_OFF_ALT_DRIVE 8'h37
`define TS_OFF_TP_CONV 8'h3d
`define TS_OFF_ALT_CONV 8'h3e
`define TS_OFF_TP_HW 8'h3f
`define TS_OFF_ALT_HW 8'h40
`define TS_OFF_TP_SET 8'h41
`define TS_OFF_GESTURE 8'h4b
`define TS_OFF_STATUS 8'he0
`define TS_OFF_TP_COUNT 8'he1
`define TS_OFF_ALT_COUNT 8'he2

// Writable bits; all others hold zero.
`define TS_MASK_ALT_DRIVE 16'h1fff
`define TS_MASK_TP_SET 16'hff3f
`define TS_MASK_GESTURE 16'hff1f

// Reset values.
`define TS_RST_ALT_DRIVE 16'h0000
`define TS_RST_CONV 16'h0000
`define TS_RST_HW 16'h0000
`define TS_RST_TP_SET 16'h0000
`define TS_RST_GESTURE 16'h0000

// Hardware settings field positions.
`define TS_HW_NOISE_BIT 15
`define TS_HW_HALF_VOLT_BIT 14
`define TS_HW_RF_BIT 13
`define TS_HW_CAP_BIT 12

// Conversion period limit and charge transfer reference table.
`define TS_PERIOD_MAX 8'h7f
`define TS_FRAC_REF 8'h7f
`define TS_RATE_2000 12'h7d0
`define TS_RATE_1000 12'h3e8
`define TS_RATE_500 12'h1f4
`define TS_RATE_350 12'h15e
`define TS_RATE_250 12'h0fa
`define TS_RATE_125 12'h07d

// Amplifier bias in microamps, count limits and cycle counts.
`define TS_BIAS_0 4'h2
`define TS_BIAS_1 4'h5
`define TS_BIAS_2 4'h7
`define TS_BIAS_3 4'ha
`define TS_MAX_0 15'h03ff
`define TS_MAX_1 15'h07ff
`define TS_MAX_2 15'h0fff
`define TS_MAX_3 15'h4000
`define TS_CYC_0 7'h04
`define TS_CYC_1 7'h08
`define TS_CYC_2 7'h10
`define TS_CYC_3 7'h20
`define TS_DLY_0 7'h04
`define TS_DLY_1 7'h10
`define TS_DLY_2 7'h20
`define TS_DLY_3 7'h40

`endif

// ===== touch_sense_pkg.sv
/*
  Types shared by the touch sensing configuration bank and its helpers.
  Assumes nothing of its surroundings.
*/
package touch_sense_pkg;

  typedef enum logic [1:0] {CONV_IDLE, CONV_DELAY, CONV_COUNT, CONV_DONE}
    conv_state_e;

  // Decoded analogue front-end settings of one channel.
  typedef struct packed {
    logic static_noise_mode;
    logic pool_cap_half_volt_discharge;
    logic rf_filter_en;
    logic pool_cap_80pf;
    logic [3:0] amp_bias_ua;
    logic [14:0] max_count;
    logic second_low_power_mode_autoprox_en;
    logic [6:0] second_low_power_mode_cycles;
    logic first_low_power_mode_autoprox_en;
    logic [6:0] first_low_power_mode_cycles;
    logic [6:0] init_delay_cycles;
  } hw_cfg_s;

  typedef struct packed {
    logic [7:0] fraction;
    logic [7:0] period;
    logic [11:0] rate_khz;
  } conv_cfg_s;

  typedef struct packed {
    logic [7:0] rx_count;
    logic moving_average_filter;
    logic iir_fixed_damping;
    logic iir_filter_en;
    logic axis_swap;
    logic flip_y;
    logic flip_x;
  } tp_cfg_s;

  typedef struct packed {
    logic [3:0] swipe_hold;
    logic [3:0] swipe;
    logic palm;
    logic press_hold;
    logic triple_tap;
    logic double_tap;
    logic single_tap;
  } gesture_s;

endpackage : touch_sense_pkg

// ===== ts_hw_decode.sv
/*
  Registered decoder from one hardware settings word to front-end values.
  Assumes the word comes from a register on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "touch_sense_map.svh"

module ts_hw_decode (
  // Clock, reset and enable.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // Settings word.
  input wire logic [15:0] i_word,
  // Decoded settings.
  output touch_sense_pkg::hw_cfg_s o_cfg
);

  // Auto-proximity code: upper bit set means disabled.
  function automatic logic [7:0] autoprox(input logic [2:0] code);
    logic [6:0] cyc;
    cyc = `TS_CYC_0;
    case (code[1:0])
      2'h1: cyc = `TS_CYC_1;
      2'h2: cyc = `TS_CYC_2;
      2'h3: cyc = `TS_CYC_3;
      default: cyc = `TS_CYC_0;
    endcase
    return {~code[2], cyc};
  endfunction : autoprox

  // Decode every field; the flops keep top outputs glitch free.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cfg <= '0;
    end else if (i_ce) begin
      o_cfg.static_noise_mode <= i_word[`TS_HW_NOISE_BIT];
      o_cfg.pool_cap_half_volt_discharge <=
        i_word[`TS_HW_HALF_VOLT_BIT];
      o_cfg.rf_filter_en <= i_word[`TS_HW_RF_BIT];
      o_cfg.pool_cap_80pf <= i_word[`TS_HW_CAP_BIT];
      case (i_word[11:10])
        2'h0: o_cfg.amp_bias_ua <= `TS_BIAS_0;
        2'h1: o_cfg.amp_bias_ua <= `TS_BIAS_1;
        2'h2: o_cfg.amp_bias_ua <= `TS_BIAS_2;
        default: o_cfg.amp_bias_ua <= `TS_BIAS_3;
      endcase
      case (i_word[9:8])
        2'h0: o_cfg.max_count <= `TS_MAX_0;
        2'h1: o_cfg.max_count <= `TS_MAX_1;
        2'h2: o_cfg.max_count <= `TS_MAX_2;
        default: o_cfg.max_count <= `TS_MAX_3;
      endcase
      {o_cfg.second_low_power_mode_autoprox_en,
       o_cfg.second_low_power_mode_cycles} <= autoprox(i_word[7:5]);
      {o_cfg.first_low_power_mode_autoprox_en,
       o_cfg.first_low_power_mode_cycles} <= autoprox(i_word[4:2]);
      case (i_word[1:0])
        2'h0: o_cfg.init_delay_cycles <= `TS_DLY_0;
        2'h1: o_cfg.init_delay_cycles <= `TS_DLY_1;
        2'h2: o_cfg.init_delay_cycles <= `TS_DLY_2;
        default: o_cfg.init_delay_cycles <= `TS_DLY_3;
      endcase
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  bias_decode_a: assert property (
    $past(i_ce) && $past(i_word[11:10]) == 2'h1
    |-> o_cfg.amp_bias_ua == `TS_BIAS_1)
    else $error("bias decode wrong");
  lp2_disable_a: assert property ($past(i_ce) && $past(i_word[7])
    |-> !o_cfg.second_low_power_mode_autoprox_en)
    else $error("second mode autoprox not off");
  lp1_cycles_a: assert property (
    $past(i_ce) && $past(i_word[4:2]) == 3'h1
    |-> o_cfg.first_low_power_mode_cycles == `TS_CYC_1)
    else $error("first mode cycles wrong");
  delay_decode_a: assert property (
    $past(i_ce) && $past(i_word[1:0]) == 2'h3
    |-> o_cfg.init_delay_cycles == `TS_DLY_3)
    else $error("init delay decode wrong");
  cap_select_a: assert property ($past(i_ce)
    |-> o_cfg.pool_cap_80pf == $past(i_word[`TS_HW_CAP_BIT])
      && o_cfg.rf_filter_en == $past(i_word[`TS_HW_RF_BIT]))
    else $error("cap or filter bit wrong");

endmodule : ts_hw_decode
`default_nettype wire

// ===== ts_conv_engine.sv
/*
  Conversion counter of one sensing channel: initial delay, then counts
  charge transfers until the count limit, then stops.
  Assumes i_xfer is a one-cycle pulse already on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ts_conv_engine (
  // Clock, reset and enable.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // Control and settings.
  input wire logic i_start,
  input wire logic i_xfer,
  input wire logic [14:0] i_max_count,
  input wire logic [6:0] i_init_delay,
  // Progress.
  output logic [14:0] o_count,
  output logic o_busy,
  output logic o_done
);

  touch_sense_pkg::conv_state_e state_reg, state_next;
  logic [6:0] delay_reg;
  logic at_limit;

  assign at_limit = (o_count + 15'h0001) == i_max_count;

  // Next state; a start while busy is ignored.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      touch_sense_pkg::CONV_IDLE:
        if (i_start) state_next = touch_sense_pkg::CONV_DELAY;
      touch_sense_pkg::CONV_DELAY:
        if (i_xfer && delay_reg == i_init_delay - 7'h01) begin
          state_next = touch_sense_pkg::CONV_COUNT;
        end
      touch_sense_pkg::CONV_COUNT:
        if (i_xfer && at_limit) begin
          state_next = touch_sense_pkg::CONV_DONE;
        end
      default: state_next = touch_sense_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) state_reg <= touch_sense_pkg::CONV_IDLE;
    else if (i_ce) state_reg <= state_next;
  end

  // Delay and conversion counters restart on every accepted start.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      delay_reg <= 7'h00;
      o_count <= 15'h0000;
    end else if (i_ce) begin
      if (state_reg == touch_sense_pkg::CONV_IDLE && i_start) begin
        delay_reg <= 7'h00;
        o_count <= 15'h0000;
      end else if (i_xfer && state_reg == touch_sense_pkg::CONV_DELAY) begin
        delay_reg <= delay_reg + 7'h01;
      end else if (i_xfer && state_reg == touch_sense_pkg::CONV_COUNT) begin
        o_count <= o_count + 15'h0001;
      end
    end
  end

  // Status flags follow the state register.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_busy <= state_next != touch_sense_pkg::CONV_IDLE;
      o_done <= state_next == touch_sense_pkg::CONV_DONE;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence reach_limit;
    state_reg == touch_sense_pkg::CONV_COUNT && i_xfer && at_limit && i_ce;
  endsequence
  sequence stop_seen;
    o_done && o_count == i_max_count ##1 !o_done || !i_ce;
  endsequence

  count_stop_a: assert property (reach_limit |=> stop_seen)
    else $error("conversion did not stop at limit");
  count_bound_a: assert property (
    i_max_count == $past(i_max_count)
    && state_reg == touch_sense_pkg::CONV_COUNT |-> o_count < i_max_count)
    else $error("count passed limit");
  delay_bound_a: assert property (
    state_reg == touch_sense_pkg::CONV_DELAY
    && i_init_delay == $past(i_init_delay) |-> delay_reg < i_init_delay)
    else $error("initial delay overran");

endmodule : ts_conv_engine
`default_nettype wire

// ===== touch_sense_config_bank.sv
/*
  Configuration register bank of the trackpad sensing engine, with the
  conversion counters it steers.
  Assumes the I2C engine presents decoded register accesses on this
  clock, and that charge transfer pins arrive from the analogue side.
*/
// What this block does
// - Bits 12:0 select alternate channel drive electrodes
// - Upper conversion byte holds frequency fraction
// - Lower conversion byte holds period, 0 to 127
// - Fraction 127 maps periods to transfer rates
// - Hardware bit 15 enables static noise mode
// - Bit 14 selects pool discharge 0V or 0.5V
// - Bit 13 enables internal RF filters
// - Bit 12 selects 40pF or 80pF pool
// - Bits 11:10 set amplifier bias current
// - Conversion stops when count reaches chosen limit
// - Bits 7:5 set second mode autoprox cycles
// - Bits 4:2 set first mode autoprox cycles
// - Bits 1:0 set initial delay cycles
// - Trackpad upper byte gives receive electrode count
// - Trackpad bit 5 enables moving average filter
// - Bit 4 selects dynamic or fixed damping
// - Bit 3 enables XY IIR filter
// - Bit 2 swaps which electrodes form columns
// - Bits 1 and 0 invert Y and X
// - Gesture bits 15:8 enable swipes and holds
// - Gesture bits 4:0 enable taps, hold, palm
`timescale 1ns/10ps
`default_nettype none
`include "touch_sense_map.svh"

module touch_sense_config_bank #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned ADDR_W = 8
) (
  // Clock, reset and enable.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // Register access from the I2C engine.
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  output logic o_reg_ack,
  // Conversion control, index 0 trackpad and 1 alternate channel.
  input wire logic [1:0] i_conv_start,
  input wire logic [1:0] i_xfer_pin,
  output logic [1:0][14:0] o_conv_count,
  output logic [1:0] o_conv_busy,
  output logic [1:0] o_conv_done,
  // Settings to the sensing engine.
  output logic [12:0] o_alt_drive_en,
  output touch_sense_pkg::conv_cfg_s [1:0] o_conv_cfg,
  output touch_sense_pkg::hw_cfg_s [1:0] o_hw_cfg,
  output touch_sense_pkg::tp_cfg_s o_tp_cfg,
  output touch_sense_pkg::gesture_s o_gesture
);

  if (DATA_W != 16 || ADDR_W != 8) begin : g_width_check
    $error("touch_sense_config_bank serves 16-bit data and 8-bit address");
  end

  logic [15:0] alt_drive_reg;
  logic [15:0] tp_set_reg;
  logic [15:0] gesture_reg;
  logic [1:0][15:0] conv_reg;
  logic [1:0][15:0] hw_reg;
  logic [1:0] xfer_meta;
  logic [1:0] xfer_sync;
  logic [1:0] xfer_prev;
  logic [1:0] xfer_pulse;
  logic [15:0] rd_data;

  // Period beyond 127 saturates, so the field never leaves its range.
  function automatic logic [15:0] conv_write(input logic [15:0] w);
    if (w[7:0] > `TS_PERIOD_MAX) return {w[15:8], `TS_PERIOD_MAX};
    return w;
  endfunction : conv_write

  // Charge transfer rate in kHz; zero where the rate is not tabulated.
  function automatic logic [11:0] rate_khz(input logic [15:0] w);
    logic [11:0] r;
    r = 12'h000;
    if (w[15:8] == `TS_FRAC_REF) begin
      case (w[7:0])
        8'h01: r = `TS_RATE_2000;
        8'h05: r = `TS_RATE_1000;
        8'h0c: r = `TS_RATE_500;
        8'h11: r = `TS_RATE_350;
        8'h1a: r = `TS_RATE_250;
        8'h35: r = `TS_RATE_125;
        default: r = 12'h000;
      endcase
    end
    return r;
  endfunction : rate_khz

  // Drive enable mask; bits 15:13 are held at zero.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      alt_drive_reg <= `TS_RST_ALT_DRIVE;
    end else if (i_ce && i_reg_wr && i_reg_addr == `TS_OFF_ALT_DRIVE) begin
      alt_drive_reg <= i_reg_wdata & `TS_MASK_ALT_DRIVE;
    end
  end

  // Trackpad layout and filter settings; bits 7:6 are held at zero.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tp_set_reg <= `TS_RST_TP_SET;
    end else if (i_ce && i_reg_wr && i_reg_addr == `TS_OFF_TP_SET) begin
      tp_set_reg <= i_reg_wdata & `TS_MASK_TP_SET;
    end
  end

  // Gesture enables; bits 7:5 are held at zero.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gesture_reg <= `TS_RST_GESTURE;
    end else if (i_ce && i_reg_wr && i_reg_addr == `TS_OFF_GESTURE) begin
      gesture_reg <= i_reg_wdata & `TS_MASK_GESTURE;
    end
  end

  // Per-channel conversion and hardware registers, then their engines.
  for (genvar g = 0; g < 2; g++) begin : g_chan
    localparam logic [7:0] CONV_OFF = g ? `TS_OFF_ALT_CONV : `TS_OFF_TP_CONV;
    localparam logic [7:0] HW_OFF = g ? `TS_OFF_ALT_HW : `TS_OFF_TP_HW;

    // Conversion frequency word.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        conv_reg[g] <= `TS_RST_CONV;
      end else if (i_ce && i_reg_wr && i_reg_addr == CONV_OFF) begin
        conv_reg[g] <= conv_write(i_reg_wdata);
      end
    end

    // Hardware settings word; every bit is defined.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        hw_reg[g] <= `TS_RST_HW;
      end else if (i_ce && i_reg_wr && i_reg_addr == HW_OFF) begin
        hw_reg[g] <= i_reg_wdata;
      end
    end

    // Conversion settings as seen by the engine.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        o_conv_cfg[g] <= '0;
      end else if (i_ce) begin
        o_conv_cfg[g].fraction <= conv_reg[g][15:8];
        o_conv_cfg[g].period <= conv_reg[g][7:0];
        o_conv_cfg[g].rate_khz <= rate_khz(conv_reg[g]);
      end
    end

    ts_hw_decode u_hw_decode (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_word(hw_reg[g]),
      .o_cfg(o_hw_cfg[g])
    );

    // The engine follows the decoded limit, one cycle behind a write.
    ts_conv_engine u_conv (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_start(i_conv_start[g]),
      .i_xfer(xfer_pulse[g]),
      .i_max_count(o_hw_cfg[g].max_count),
      .i_init_delay(o_hw_cfg[g].init_delay_cycles),
      .o_count(o_conv_count[g]),
      .o_busy(o_conv_busy[g]),
      .o_done(o_conv_done[g])
    );
  end

  // Transfer pins are asynchronous; two flops, then an edge detector.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      xfer_meta <= 2'h0;
      xfer_sync <= 2'h0;
      xfer_prev <= 2'h0;
    end else if (i_ce) begin
      xfer_meta <= i_xfer_pin;
      xfer_sync <= xfer_meta;
      xfer_prev <= xfer_sync;
    end
  end

  assign xfer_pulse = xfer_sync & ~xfer_prev;

  // Electrode, layout and gesture settings to the engine.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_alt_drive_en <= 13'h0000;
      o_tp_cfg <= '0;
      o_gesture <= '0;
    end else if (i_ce) begin
      o_alt_drive_en <= alt_drive_reg[12:0];
      o_tp_cfg.rx_count <= tp_set_reg[15:8];
      o_tp_cfg.moving_average_filter <= tp_set_reg[5];
      o_tp_cfg.iir_fixed_damping <= tp_set_reg[4];
      o_tp_cfg.iir_filter_en <= tp_set_reg[3];
      o_tp_cfg.axis_swap <= tp_set_reg[2];
      o_tp_cfg.flip_y <= tp_set_reg[1];
      o_tp_cfg.flip_x <= tp_set_reg[0];
      o_gesture.swipe_hold <= gesture_reg[15:12];
      o_gesture.swipe <= gesture_reg[11:8];
      o_gesture.palm <= gesture_reg[4];
      o_gesture.press_hold <= gesture_reg[3];
      o_gesture.triple_tap <= gesture_reg[2];
      o_gesture.double_tap <= gesture_reg[1];
      o_gesture.single_tap <= gesture_reg[0];
    end
  end

  // Read decode; unmapped offsets answer zero rather than an error.
  always_comb begin
    if (i_reg_addr == `TS_OFF_ALT_DRIVE) begin
      rd_data = alt_drive_reg;
    end else if (i_reg_addr == `TS_OFF_TP_CONV) begin
      rd_data = conv_reg[0];
    end else if (i_reg_addr == `TS_OFF_ALT_CONV) begin
      rd_data = conv_reg[1];
    end else if (i_reg_addr == `TS_OFF_TP_HW) begin
      rd_data = hw_reg[0];
    end else if (i_reg_addr == `TS_OFF_ALT_HW) begin
      rd_data = hw_reg[1];
    end else if (i_reg_addr == `TS_OFF_TP_SET) begin
      rd_data = tp_set_reg;
    end else if (i_reg_addr == `TS_OFF_GESTURE) begin
      rd_data = gesture_reg;
    end else if (i_reg_addr == `TS_OFF_STATUS) begin
      rd_data = {12'h000, o_conv_done, o_conv_busy};
    end else if (i_reg_addr == `TS_OFF_TP_COUNT) begin
      rd_data = {1'b0, o_conv_count[0]};
    end else if (i_reg_addr == `TS_OFF_ALT_COUNT) begin
      rd_data = {1'b0, o_conv_count[1]};
    end else begin
      rd_data = 16'h0000;
    end
  end

  // Read data and the acknowledge come one cycle after the access.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack <= 1'b0;
    end else if (i_ce) begin
      o_reg_ack <= i_reg_rd | i_reg_wr;
      if (i_reg_rd) o_reg_rdata <= rd_data;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence drive_write;
    i_ce && i_reg_wr && i_reg_addr == `TS_OFF_ALT_DRIVE;
  endsequence
  sequence drive_readback;
    i_ce && i_reg_rd && i_reg_addr == `TS_OFF_ALT_DRIVE;
  endsequence

  // The host leaves an idle cycle between accesses, so allow one here.
  drive_mask_a: assert property (
    drive_write ##1 !i_reg_wr ##1 drive_readback
    |=> o_reg_rdata == ($past(i_reg_wdata, 3) & `TS_MASK_ALT_DRIVE))
    else $error("drive readback not masked");
  drive_out_a: assert property (drive_write ##1 i_ce
    |=> o_alt_drive_en == $past(i_reg_wdata[12:0], 2))
    else $error("drive enables not applied");
  fraction_out_a: assert property (i_ce && i_reg_wr
    && i_reg_addr == `TS_OFF_TP_CONV ##1 i_ce
    |=> o_conv_cfg[0].fraction == $past(i_reg_wdata[15:8], 2))
    else $error("fraction not applied");
  period_range_a: assert property (conv_reg[0][7:0] <= `TS_PERIOD_MAX
    && conv_reg[1][7:0] <= `TS_PERIOD_MAX)
    else $error("period out of range");
  rate_ref_a: assert property (
    $past(i_ce) && $past(conv_reg[0]) == 16'h7f01
    |-> o_conv_cfg[0].rate_khz == `TS_RATE_2000)
    else $error("rate table wrong");
  // The decoder lags its word by one edge, so compare one cycle back.
  noise_mode_a: assert property (i_ce ##1 i_ce
    |=> o_hw_cfg[1].static_noise_mode == $past(hw_reg[1][15]))
    else $error("static noise mode wrong");
  discharge_a: assert property (i_ce ##1 i_ce
    |=> o_hw_cfg[0].pool_cap_half_volt_discharge == $past(hw_reg[0][14]))
    else $error("discharge level wrong");
  rf_filter_a: assert property (i_ce ##1 i_ce
    |=> o_hw_cfg[1].rf_filter_en == $past(hw_reg[1][13]))
    else $error("rf filter wrong");
  rx_count_a: assert property ($past(i_ce)
    |-> o_tp_cfg.rx_count == $past(tp_set_reg[15:8]))
    else $error("receive count wrong");
  filters_a: assert property ($past(i_ce)
    |-> {o_tp_cfg.moving_average_filter, o_tp_cfg.iir_fixed_damping,
    o_tp_cfg.iir_filter_en} == $past(tp_set_reg[5:3]))
    else $error("filter bits wrong");
  orient_a: assert property ($past(i_ce) |-> {o_tp_cfg.axis_swap,
    o_tp_cfg.flip_y, o_tp_cfg.flip_x} == $past(tp_set_reg[2:0]))
    else $error("orientation bits wrong");
  gesture_out_a: assert property ($past(i_ce)
    |-> {o_gesture.swipe_hold, o_gesture.swipe} == $past(gesture_reg[15:8])
    && o_gesture.palm == $past(gesture_reg[4])
    && o_gesture.single_tap == $past(gesture_reg[0]))
    else $error("gesture enables wrong");
  unused_zero_a: assert property (tp_set_reg[7:6] == 2'h0
    && gesture_reg[7:5] == 3'h0 && alt_drive_reg[15:13] == 3'h0)
    else $error("unused bits not zero");

endmodule : touch_sense_config_bank
`default_nettype wire

// ===== ts_host_model.sv
/*
  Host model of the register port: one access at a time.
  Assumes a one-cycle strobe and an acknowledge one cycle after it.
*/
`timescale 1ns/10ps
`default_nettype none
module ts_host_model (
  // Bus side.
  input wire logic i_clk_sys,
  input wire logic [15:0] i_rdata,
  input wire logic i_ack,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  // Idle bus from time zero.
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end

  // A missing acknowledge returns 0xdead, a pattern only the hardware settings registers can hold.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_wdata <= ~d;
    #1;
    q = i_ack ? i_rdata : 16'hdead;
  endtask : acc
endmodule : ts_host_model
`default_nettype wire

// ===== touch_sense_config_bank_test.sv
/*
  Self-checking bench of the configuration bank.
  Assumes the host model and the bank share one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module touch_sense_config_bank_test;
  logic i_clk_sys, i_rst, i_reg_wr, i_reg_rd, o_reg_ack;
  logic [7:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, q;
  logic [1:0] i_conv_start, i_xfer_pin, o_conv_busy, o_conv_done;
  logic [1:0][14:0] o_conv_count;
  logic [12:0] o_alt_drive_en;
  touch_sense_pkg::conv_cfg_s [1:0] o_conv_cfg;
  touch_sense_pkg::hw_cfg_s [1:0] o_hw_cfg;
  touch_sense_pkg::tp_cfg_s o_tp_cfg;
  touch_sense_pkg::gesture_s o_gesture;
  int miscompares = 0, num_checks = 0, cyc = 0, dn = 0;

  touch_sense_config_bank touch_sense_config_bank_i (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_ce(1'b1), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
    .i_conv_start(i_conv_start), .i_xfer_pin(i_xfer_pin),
    .o_conv_count(o_conv_count), .o_conv_busy(o_conv_busy),
    .o_conv_done(o_conv_done), .o_alt_drive_en(o_alt_drive_en),
    .o_conv_cfg(o_conv_cfg), .o_hw_cfg(o_hw_cfg), .o_tp_cfg(o_tp_cfg),
    .o_gesture(o_gesture));
  ts_host_model ts_host_model_i (.i_clk_sys(i_clk_sys),
    .i_rdata(o_reg_rdata), .i_ack(o_reg_ack), .o_addr(i_reg_addr),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));

  // Clock, done-pulse tally and hang guard.
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    dn = dn + o_conv_done[0] + o_conv_done[1];
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // All ones everywhere: reserved bits must drop, the period saturates.
  task automatic t_masks;
    logic [7:0] a[7] = '{8'h37, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h4b};
    logic [15:0] e[7] = '{16'h1fff, 16'hff7f, 16'hff7f, 16'hffff, 16'hffff,
                          16'hff3f, 16'hff1f};
    for (int k = 0; k < 7; k++) begin
      ts_host_model_i.acc(1'b1, a[k], 16'hffff, q);
      ts_host_model_i.acc(1'b0, a[k], 16'h0000, q);
      cmp("readback", e[k], q);
    end
    ts_host_model_i.acc(1'b0, 8'h50, 16'h0000, q);
    cmp("unmapped", 16'h0000, q);
    cmp("drive", 16'h1fff, {3'h0, o_alt_drive_en});
    cmp("period", 16'h007f, {8'h00, o_conv_cfg[1].period});
    cmp("tp", 16'hff3f, {o_tp_cfg[13:6], 2'b00, o_tp_cfg[5:0]});
    cmp("gest", 16'hff1f, {o_gesture[12:5], 3'h0, o_gesture[4:0]});
  endtask : t_masks

  // Fraction 127 with each listed period code.
  task automatic t_rates;
    logic [7:0] p[6] = '{8'h01, 8'h05, 8'h0c, 8'h11, 8'h1a, 8'h35};
    logic [11:0] r[6] = '{12'h7d0, 12'h3e8, 12'h1f4, 12'h15e, 12'h0fa,
                          12'h07d};
    for (int k = 0; k < 6; k++) begin
      ts_host_model_i.acc(1'b1, 8'h3d, {8'h7f, p[k]}, q);
      repeat (2) @(posedge i_clk_sys);
      #1;
      cmp("rate", {4'h0, r[k]}, {4'h0, o_conv_cfg[0].rate_khz});
      cmp("frac", 16'h007f, {8'h00, o_conv_cfg[0].fraction});
    end
  endtask : t_rates

  // Word 0xa6e6 mixes set and clear flags with mid-range codes.
  task automatic t_hw;
    touch_sense_pkg::hw_cfg_s h;
    ts_host_model_i.acc(1'b1, 8'h3f, 16'ha6e6, q);
    repeat (3) @(posedge i_clk_sys);
    #1;
    h = o_hw_cfg[0];
    cmp("noise", 16'h0001, {15'h0, h.static_noise_mode});
    cmp("half", 16'h0000, {15'h0, h.pool_cap_half_volt_discharge});
    cmp("rf", 16'h0001, {15'h0, h.rf_filter_en});
    cmp("cap", 16'h0000, {15'h0, h.pool_cap_80pf});
    cmp("bias", 16'h0005, {12'h0, h.amp_bias_ua});
    cmp("max", 16'h0fff, {1'b0, h.max_count});
    cmp("lp2", 16'h0000,
        {15'h0, h.second_low_power_mode_autoprox_en});
    cmp("lp1", 16'h0108, {7'h0, h.first_low_power_mode_autoprox_en, 1'b0,
        h.first_low_power_mode_cycles});
    cmp("delay", 16'h0020, {9'h0, h.init_delay_cycles});
  endtask : t_hw

  // Both channels with limit 1023 and delay 4; extra pulses must not count.
  task automatic t_conv;
    ts_host_model_i.acc(1'b1, 8'h3f, 16'h0000, q);
    ts_host_model_i.acc(1'b1, 8'h40, 16'h0000, q);
    repeat (3) @(posedge i_clk_sys);
    i_conv_start <= 2'b11;
    @(posedge i_clk_sys);
    i_conv_start <= 2'b00;
    dn = 0;
    repeat (2060) begin
      repeat (2) @(posedge i_clk_sys);
      i_xfer_pin <= ~i_xfer_pin;
    end
    repeat (8) @(posedge i_clk_sys);
    #1;
    cmp("count0", 16'h03ff, {1'b0, o_conv_count[0]});
    cmp("count1", 16'h03ff, {1'b0, o_conv_count[1]});
    cmp("busy", 16'h0000, {14'h0, o_conv_busy});
    cmp("dones", 16'h0002, dn[15:0]);
    ts_host_model_i.acc(1'b0, 8'he1, 16'h0000, q);
    cmp("count reg", 16'h03ff, q);
  endtask : t_conv

  // Main sequence.
  initial begin
    i_rst = 1'b1;
    i_conv_start = 2'b00;
    i_xfer_pin = 2'b00;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_masks();
    t_rates();
    t_hw();
    t_conv();
    final_report();
  end
endmodule : touch_sense_config_bank_test
`default_nettype wire
